// ==== logic/otf_pkg.sv ====
/*
 Constants for the over-temperature fault response block: register codes,
 field positions, reset values and timing counts.
 Assumes the register port is a simple command-code addressed write/read port.
*/
// Overview of operation
// - Hold a 16-bit over-temperature threshold in linear format, degrees Celsius.
// - Action 00: keep running through an over-temperature fault.
// - Action 01: run for the delay; if fault persists, follow retry field.
// - Action 10: disable output at once, then follow retry field.
// - Action 11: stay disabled until cleared; clearing status bit clears it.
// - Clear-faults command or reset input clears a latched fault.
// - Output commanded off then on clears a latched fault.
// - Retry 000: no restart, stay disabled until cleared.
// - Retry 001: one restart attempt, then latch off.
// - Retry 010: two restart attempts, then latch off.
// - Retry 011: three restart attempts, then latch off.
// - Retry 100: four restart attempts, then latch off.
// - Attempt-to-attempt interval is delay count times delay unit.
// - Retry 101 and 110: five and six attempts, then latch off.
// - Retry 111: retry without limit until commanded off.
// - Delay codes 0,1,2,3,5,6,7 mean 1,2,8,16,32,64,128 units.
// - Delay unit length comes from the time-unit configuration input.
package otf_pkg;
    localparam logic [7:0]  REG_THRESHOLD   = 8'h4F;
    localparam logic [7:0]  REG_ACTION      = 8'h50;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0]  ACTION_RESET    = 8'h00;
    localparam int          RESP_MSB        = 7;
    localparam int          RESP_LSB        = 6;
    localparam int          RETRY_MSB       = 5;
    localparam int          RETRY_LSB       = 3;
    localparam int          DELAY_MSB       = 2;
    localparam int          DELAY_LSB       = 0;
    localparam logic [1:0]  RESP_IGNORE     = 2'h0;
    localparam logic [1:0]  RESP_RUN_RETRY  = 2'h1;
    localparam logic [1:0]  RESP_DIS_RETRY  = 2'h2;
    localparam logic [1:0]  RESP_LATCH      = 2'h3;
    localparam logic [2:0]  RETRY_NONE      = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
    localparam int          CLK_MHZ         = 50;
    localparam int          UNIT_US_DEFAULT = 1;
    localparam int          UNIT_CYCLES     = UNIT_US_DEFAULT * CLK_MHZ;
    typedef enum logic [2:0] {OTF_RUN, OTF_WAIT_RUN, OTF_OFF_WAIT, OTF_RESTART, OTF_LATCHED} otf_state_e;
endpackage : otf_pkg

// ==== logic/otf_fault_response.sv ====
/*
 Over-temperature fault response: threshold and action registers, fault
 detection, delay timing, retry counting and output latch-off.
 Assumes temperature is a linear-format word on the same clock, and the
 command port is driven by the bus front end on the same clock.
*/
`timescale 1ns/1ps
module otf_fault_response
    import otf_pkg::*;
#(
    parameter int UNIT_CYCLES_P = UNIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_code,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_valid,
    input  wire logic        clear_faults,
    input  wire logic        clear_status_bit,
    input  wire logic        output_cmd_on,
    input  wire logic [15:0] unit_cycles_cfg,
    input  wire logic [15:0] temperature,
    output logic             output_enable,
    output logic             fault_status,
    output logic [2:0]       attempts_made
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] threshold_reg;
    logic [7:0]  action_reg;
    otf_state_e  state_reg;
    logic [15:0] unit_cnt_reg;
    logic [7:0]  units_left_reg;
    logic [2:0]  attempts_reg;
    logic        cmd_on_d_reg;
    logic        fault_now;
    logic        clear_evt;
    logic        unit_tick;
    logic [7:0]  delay_units;
    logic [1:0]  resp;
    logic [2:0]  retry;
    logic [15:0] unit_len;

    assign resp  = action_reg[RESP_MSB:RESP_LSB];
    assign retry = action_reg[RETRY_MSB:RETRY_LSB];

    // Linear words compared as signed; exponent equal assumed by the caller
    assign fault_now = $signed(temperature) > $signed(threshold_reg);

    // Falling then rising command counts as a power cycle clear
    assign clear_evt = clear_faults | clear_status_bit | (output_cmd_on & ~cmd_on_d_reg);

    // Zero unit length is not meaningful, so it falls back to the default
    assign unit_len  = (unit_cycles_cfg == 16'h0000) ? UNIT_CYCLES_P[15:0] : unit_cycles_cfg;
    assign unit_tick = (unit_cnt_reg == unit_len - 16'h0001);

    // Code 4 is not listed; it is treated like code 3 (16 units)
    always_comb begin
        unique case (action_reg[DELAY_MSB:DELAY_LSB])
            3'h0: delay_units = 8'h01;
            3'h1: delay_units = 8'h02;
            3'h2: delay_units = 8'h08;
            3'h3: delay_units = 8'h10;
            3'h4: delay_units = 8'h10;
            3'h5: delay_units = 8'h20;
            3'h6: delay_units = 8'h40;
            3'h7: delay_units = 8'h80;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            threshold_reg <= THRESHOLD_RESET;
            action_reg    <= ACTION_RESET;
        end else if (reg_wr) begin
            if (reg_code == REG_THRESHOLD) begin
                threshold_reg <= reg_wdata;
            end
            if (reg_code == REG_ACTION) begin
                action_reg <= reg_wdata[7:0];
            end
        end
    end

    // Register reads; unmapped codes return zero with valid
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
            reg_valid <= 1'b0;
        end else begin
            reg_valid <= reg_rd;
            if (reg_rd) begin
                if (reg_code == REG_THRESHOLD) begin
                    reg_rdata <= threshold_reg;
                end else if (reg_code == REG_ACTION) begin
                    reg_rdata <= {8'h00, action_reg};
                end else begin
                    reg_rdata <= 16'h0000;
                end
            end
        end
    end

    // Command edge history; resets to on so a host holding the output on
    // through reset does not look like an off-on clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_on_d_reg <= 1'b1;
        end else begin
            cmd_on_d_reg <= output_cmd_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay unit prescaler, restarted whenever a new delay begins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unit_cnt_reg <= 16'h0000;
        end else if (state_reg == OTF_RUN || state_reg == OTF_RESTART || state_reg == OTF_LATCHED || unit_tick) begin
            unit_cnt_reg <= 16'h0000;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= OTF_RUN;
            units_left_reg <= 8'h00;
            attempts_reg   <= 3'h0;
        end else if (clear_evt || !output_cmd_on) begin
            // Clear and command-off both end any retry sequence
            state_reg      <= OTF_RUN;
            attempts_reg   <= 3'h0;
            units_left_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                OTF_RUN: begin
                    units_left_reg <= delay_units;
                    if (fault_now) begin
                        unique case (resp)
                            RESP_IGNORE:    state_reg <= OTF_RUN;
                            RESP_RUN_RETRY: state_reg <= OTF_WAIT_RUN;
                            RESP_DIS_RETRY: state_reg <= (retry == RETRY_NONE) ? OTF_LATCHED : OTF_OFF_WAIT;
                            RESP_LATCH:     state_reg <= OTF_LATCHED;
                        endcase
                    end
                end
                OTF_WAIT_RUN: begin
                    // Output stays on while the delay runs
                    if (unit_tick) begin
                        units_left_reg <= units_left_reg - 8'h01;
                        if (units_left_reg == 8'h01) begin
                            units_left_reg <= delay_units;
                            if (!fault_now) begin
                                state_reg <= OTF_RUN;
                            end else begin
                                state_reg <= (retry == RETRY_NONE) ? OTF_LATCHED : OTF_OFF_WAIT;
                            end
                        end
                    end
                end
                OTF_OFF_WAIT: begin
                    if (unit_tick) begin
                        units_left_reg <= units_left_reg - 8'h01;
                        if (units_left_reg == 8'h01) begin
                            state_reg <= OTF_RESTART;
                        end
                    end
                end
                OTF_RESTART: begin
                    // One restart attempt: output back on, fault sampled again
                    units_left_reg <= delay_units;
                    if (retry != RETRY_FOREVER) begin
                        attempts_reg <= attempts_reg + 3'h1;
                    end
                    if (!fault_now) begin
                        state_reg    <= OTF_RUN;
                        attempts_reg <= 3'h0;
                    end else if (retry == RETRY_FOREVER) begin
                        state_reg <= OTF_OFF_WAIT;
                    end else if (attempts_reg + 3'h1 >= retry) begin
                        state_reg <= OTF_LATCHED;
                    end else begin
                        state_reg <= OTF_OFF_WAIT;
                    end
                end
                OTF_LATCHED: begin
                    state_reg <= OTF_LATCHED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drive and status
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_enable <= 1'b0;
            fault_status  <= 1'b0;
        end else begin
            output_enable <= output_cmd_on & (state_reg == OTF_RUN || state_reg == OTF_WAIT_RUN || state_reg == OTF_RESTART);
            // Set wins over a clear in the same cycle
            if (fault_now && resp != RESP_IGNORE) begin
                fault_status <= 1'b1;
            end else if (clear_evt) begin
                fault_status <= 1'b0;
            end
        end
    end

    assign attempts_made = attempts_reg;
endmodule : otf_fault_response

// ==== testbench/otf_fault_response_properties.sv ====
/* Port checker for otf_fault_response.
   Assumes one clock domain; bound to the design below. */
`timescale 1ns/1ps
module otf_fault_response_properties
    import otf_pkg::*;
#(
    parameter int UNIT_CYCLES_P = 50
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_code,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_valid,
    input wire logic        clear_faults,
    input wire logic        clear_status_bit,
    input wire logic        output_cmd_on,
    input wire logic [15:0] unit_cycles_cfg,
    input wire logic [15:0] temperature,
    input wire logic        output_enable,
    input wire logic        fault_status,
    input wire logic [2:0]  attempts_made
);
    ////////////////////////////////////////////////////////////////
    logic [15:0] thr_reg;
    logic [7:0]  act_reg;
    logic [1:0]  clr_reg;
    wire         clr_any = clear_faults | clear_status_bit | ~output_cmd_on;
    wire         hot     = $signed(temperature) > $signed(thr_reg);
    // Shadow registers; clears are remembered two cycles since they land late
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            thr_reg <= 16'h0000;
            act_reg <= 8'h00;
            clr_reg <= 2'h0;
        end else begin
            if (reg_wr && reg_code == REG_THRESHOLD) thr_reg <= reg_wdata;
            if (reg_wr && reg_code == REG_ACTION) act_reg <= reg_wdata[7:0];
            clr_reg <= {clr_reg[0], clr_any};
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_ign;
        act_reg[7:6] == RESP_IGNORE && output_cmd_on;
    endsequence
    // Property checks
    chk_read_answer: assert property (reg_rd |=> reg_valid && $past(reg_rd))
        else $error("read not answered");
    chk_valid_pulse: assert property (!reg_rd |=> !reg_valid)
        else $error("stray read valid");
    chk_unmapped_zero: assert property (reg_rd && reg_code != REG_THRESHOLD && reg_code != REG_ACTION
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    chk_thr_readback: assert property (reg_rd && !reg_wr && reg_code == REG_THRESHOLD
        |=> reg_rdata == thr_reg) else $error("threshold readback wrong");
    chk_ignore_runs: assert property (s_ign ##0 output_enable ##1 s_ign |-> output_enable)
        else $error("output dropped while ignoring");
    chk_disable_fast: assert property (act_reg[7] && hot && output_enable && !reg_wr
        |-> ##[1:2] !output_enable) else $error("output not disabled on fault");
    chk_latch_holds: assert property (fault_status && !output_enable && act_reg[7:6] == RESP_LATCH
        && !clr_any && clr_reg == 2'h0 |=> !output_enable) else $error("latch released");
    chk_retry_bound: assert property (act_reg[5:3] != RETRY_FOREVER
        |-> attempts_made <= act_reg[5:3]) else $error("too many restarts");
    chk_fault_flag: assert property (act_reg[7:6] != RESP_IGNORE && hot && !reg_wr
        |=> fault_status) else $error("fault not flagged");
endmodule : otf_fault_response_properties
bind otf_fault_response otf_fault_response_properties #(.UNIT_CYCLES_P(UNIT_CYCLES_P)) i_chk (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_code(reg_code),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_valid(reg_valid), .clear_faults(clear_faults),
    .clear_status_bit(clear_status_bit), .output_cmd_on(output_cmd_on), .unit_cycles_cfg(unit_cycles_cfg),
    .temperature(temperature), .output_enable(output_enable), .fault_status(fault_status),
    .attempts_made(attempts_made));

// ==== testbench/otf_host_model.sv ====
/* Host and sensor model: temperature word and on/off command.
   Assumes requests arrive just after a rising edge. */
`timescale 1ns/1ps
module otf_host_model (
    input  wire logic        clk,
    input  wire logic        hot,
    input  wire logic        cycle_req,
    output logic      [15:0] temperature,
    output logic             output_cmd_on
);
    // Off for one cycle then back on clears a latched fault
    initial temperature = 16'h0020;
    initial output_cmd_on = 1'b1;
    // Updated on the edge so the bench's own 1 ns stimulus never races it
    always @(posedge clk) begin
        temperature <= hot ? 16'h0060 : 16'h0020;
        output_cmd_on <= ~cycle_req;
    end
endmodule : otf_host_model

// ==== testbench/testbench.sv ====
/* Self-checking bench for otf_fault_response.
   Assumes the host model drives temperature and the on/off command. */
`timescale 1ns/1ps
module testbench;
    import otf_pkg::*;
    logic        clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, hot = 0, cycle_req = 0;
    logic        clear_faults = 0, clear_status_bit = 0;
    logic [7:0]  reg_code = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    wire  [15:0] reg_rdata, temperature;
    wire         reg_valid, output_enable, fault_status, output_cmd_on;
    wire  [2:0]  attempts_made;
    int          fail_count = 0, compares = 0, ons = 0;
    always #10 clk = ~clk;
    otf_fault_response #(.UNIT_CYCLES_P(2)) i_dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_code(reg_code), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_valid(reg_valid), .clear_faults(clear_faults), .clear_status_bit(clear_status_bit),
        .output_cmd_on(output_cmd_on), .unit_cycles_cfg(16'h0002), .temperature(temperature),
        .output_enable(output_enable), .fault_status(fault_status), .attempts_made(attempts_made));
    otf_host_model i_host (.clk(clk), .hot(hot), .cycle_req(cycle_req), .temperature(temperature),
        .output_cmd_on(output_cmd_on));
    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Waits are left 1 ns past the edge so outputs have settled
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task wr(input logic [7:0] c, input logic [15:0] d);
        cyc(1);
        reg_code = c;
        reg_wdata = d;
        reg_wr = 1;
        cyc(1);
        reg_wr = 0;
    endtask : wr
    task rd(input logic [7:0] c, input logic [15:0] exp);
        cyc(1);
        reg_code = c;
        reg_rd = 1;
        cyc(1);
        reg_rd = 0;
        check("reg_rdata", reg_rdata, exp);
        check("reg_valid", 16'(reg_valid), 16'h0001);
    endtask : rd
    // Three ways to clear a latched fault
    task clr(input int m);
        clear_faults = (m == 0);
        clear_status_bit = (m == 1);
        cycle_req = (m == 2);
        cyc(1);
        {clear_faults, clear_status_bit, cycle_req} = 3'h0;
    endtask : clr
    task conclude;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        reset_n = 1;
        rd(REG_THRESHOLD, 16'h0000);
        rd(REG_ACTION, 16'h0000);
        rd(8'h51, 16'h0000);
        wr(REG_THRESHOLD, 16'h0050);
        rd(REG_THRESHOLD, 16'h0050);
        hot = 1;
        cyc(40);
        check("ignore_on", 16'(output_enable), 16'h0001);
        $display("test ignore done");
        hot = 0;
        wr(REG_ACTION, 16'h004A);
        hot = 1;
        cyc(10);
        check("run_on", 16'(output_enable), 16'h0001);
        cyc(60);
        check("run_off", 16'(output_enable), 16'h0000);
        hot = 0;
        clr(0);
        cyc(5);
        check("cleared", 16'(output_enable), 16'h0001);
        $display("test run retry done");
        wr(REG_ACTION, 16'h00C8);
        hot = 1;
        cyc(5);
        check("latch_off", 16'(output_enable), 16'h0000);
        hot = 0;
        cyc(40);
        check("latch_hold", 16'(output_enable), 16'h0000);
        clr(1);
        cyc(5);
        check("latch_clr", 16'(output_enable), 16'h0001);
        reset_n = 0;
        cyc(2);
        reset_n = 1;
        rd(REG_ACTION, 16'h0000);
        $display("test latch done");
        wr(REG_THRESHOLD, 16'h0050);
        for (int r = 0; r < 7; r++) begin
            wr(REG_ACTION, {8'h00, RESP_DIS_RETRY, 3'(r), 3'h0});
            hot = 1;
            cyc(3);
            check("dis_off", 16'(output_enable), 16'h0000);
            check("flag", 16'(fault_status), 16'h0001);
            cyc(20 * r + 20);
            check("attempts", 16'(attempts_made), 16'(r));
            check("final_off", 16'(output_enable), 16'h0000);
            hot = 0;
            clr(r % 3);
            cyc(6);
            check("retry_clr", 16'(output_enable), 16'h0001);
        end
        $display("test retry counts done");
        // Endless retry: restarts keep coming, count never grows, off-on stops it
        wr(REG_ACTION, {8'h00, RESP_DIS_RETRY, RETRY_FOREVER, 3'h0});
        hot = 1;
        repeat (40) begin
            cyc(1);
            ons += int'(output_enable);
        end
        check("forever_ons", 16'(ons > 3), 16'h0001);
        check("forever_cnt", 16'(attempts_made), 16'h0000);
        hot = 0;
        clr(2);
        cyc(6);
        check("forever_clr", 16'(output_enable), 16'h0001);
        $display("test retry forever done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule : testbench
